// >>> logic/lpc_dev.sv
`timescale 1ns/10ps
// Function
// RULE1: Commands decoded from CS, CA0-3, CKE at rise
// RULE2: Three bank bits choose the bank
// RULE3: Auto-precharge bit precharges bank after burst
// RULE4: Self refresh, deep power down exit asynchronous
// RULE5: Per-bank refresh only with eight banks
// RULE6: Column bit zero implied zero
// RULE7: CKE low twice keeps low-power state
// RULE8: CKE rise leaves active or idle power down
// RULE9: Resetting power down exit checks init interval
// RULE10: Deep power down exit goes to power on
// RULE11: After self refresh exit, NOPs for tXSR
// RULE12: After power-down exit, NOPs for tXP
// RULE13: Banks active, CKE fall: active power down
// RULE14: All idle, CKE fall: idle power down
// RULE15: CKE fall with command: self refresh, DPD
// RULE16: Resetting, CKE fall: resetting power down
// RULE17: Idle commands move to their own states
// RULE18: Row active: read, write, MRR, precharge
// RULE19: Reading: read, write, terminate to active
// RULE20: Writing: write, read, terminate to active
// RULE21: Reset starts init; MRR while resetting
// RULE22: Bank idle/active only after timing met
module lpc_dev
	import lpc_pkg::*;
(
	input  wire logic          core_clk_i,
	input  wire logic          rst_i,
	lpc_link_if.dev            link,
	output lpc_dev_t           dev_state_o,
	output logic [NUM_BANKS-1:0] bank_active_o,
	output logic [NUM_BANKS-1:0] bank_idle_o,
	output logic               cmd_stb_o,
	output lpc_cmd_t           cmd_o,
	output logic [BA_W-1:0]    ba_o,
	output logic [14:0]        row_o,
	output logic [11:0]        col_o,
	output logic               ap_o,
	output logic [7:0]         ma_o,
	output logic [7:0]         op_o
);
	// ****************************************
	// Pin synchroniser and edge detect
	// ****************************************
	logic [CA_W+2:0] sy1;
	logic [CA_W+2:0] sy2;
	logic            ck_s;
	logic            cke_s;
	logic            cs_s;
	logic [CA_W-1:0] ca_s;
	logic            ck_d;
	logic            rise;
	logic            fall;

	always_ff @(posedge core_clk_i) begin
		sy1 <= {link.ck, link.cke, link.cs_n, link.ca};
		sy2 <= sy1;
	end
	assign {ck_s, cke_s, cs_s, ca_s} = sy2;
	assign rise = ck_s & ~ck_d;
	assign fall = ~ck_s & ck_d;

	// ****************************************
	// Command decode
	// ****************************************
	logic [CA_W-1:0] h1;
	lpc_cmd_t        dcmd;
	logic [7:0]      ma;

	assign ma = {ca_s[1:0], h1[9:4]};
	always_comb begin
		dcmd = CMD_NOP;
		if (h1[1:0] == OP_ACT) begin
			dcmd = CMD_ACT;
		end else if (h1[2:0] == OP_WR) begin
			dcmd = CMD_WR;
		end else if (h1[2:0] == OP_RD) begin
			dcmd = CMD_RD;
		end else if (h1[3:0] == OP_MRW) begin
			dcmd = CMD_MRW;
		end else if (h1[3:0] == OP_MRR) begin
			dcmd = CMD_MRR;
		end else if (h1[3:0] == OP_REFPB) begin
			dcmd = CMD_REF_PB;
		end else if (h1[3:0] == OP_REFAB) begin
			dcmd = CMD_REF_AB;
		end else if (h1[3:0] == OP_PRE) begin
			dcmd = CMD_PRE;
		end else if (h1[3:0] == OP_BST) begin
			dcmd = CMD_BST;
		end
	end

	// ****************************************
	// Device state
	// ****************************************
	logic            cke_p, next_cke_p, next_ck_d, pend, next_pend;
	logic [CA_W-1:0] next_h1;
	lpc_dev_t        st, next_st, ret, next_ret;
	logic [TW-1:0]   gtmr, next_gtmr, itmr, next_itmr;
	logic [BA_W-1:0] last_ba, next_last_ba;
	logic            next_stb, next_ap;
	lpc_cmd_t        next_cmd;
	logic [BA_W-1:0] next_ba;
	logic [14:0]     next_row;
	logic [11:0]     next_col;
	logic [7:0]      next_ma, next_op;
	logic            all_idle, exe, bk_go, bk_rst;
	logic [BA_W-1:0] bk_ba;

	assign all_idle = &bank_idle_o;
	assign exe      = fall & pend;

	always_comb begin
		next_ck_d    = ck_s;
		next_cke_p   = cke_p;
		next_h1      = h1;
		next_pend    = pend;
		next_st      = st;
		next_ret     = ret;
		next_gtmr    = (gtmr != '0) ? gtmr - 1'b1 : gtmr;
		next_itmr    = (itmr != '0) ? itmr - 1'b1 : itmr;
		next_last_ba = last_ba;
		next_stb     = 1'b0;
		next_cmd     = cmd_o;
		next_ba      = ba_o;
		next_row     = row_o;
		next_col     = col_o;
		next_ap      = ap_o;
		next_ma      = ma_o;
		next_op      = op_o;
		bk_go        = 1'b0;
		bk_rst       = 1'b0;
		bk_ba        = (dcmd == CMD_BST) ? last_ba : h1[BA_LSB +: BA_W];
		case (st)
			S_SREF: if (cke_s && cs_s) next_st = S_NORM;                    // RULE4
			S_DPD: if (cke_s && cs_s) next_st = S_PWRON;                    // RULE10
			S_BUSY: if (gtmr == '0) next_st = ret;
			S_RST: if (itmr == '0) next_st = S_NORM;
			default: ;
		endcase
		if (rise) begin
			next_cke_p = cke_s;
			next_h1    = ca_s;
			next_pend  = cke_p && cke_s && !cs_s && (st inside {S_PWRON, S_RST, S_NORM}); // RULE1 RULE7
			if (cke_p && !cke_s) begin
				if (st == S_NORM && cs_s) begin
					next_st = all_idle ? S_IDLE_PD : S_ACT_PD;              // RULE13 RULE14
				end else if (st == S_NORM && all_idle && !cs_s && ca_s[3:0] == OP_REFPB) begin
					next_st = S_SREF;                                       // RULE15
				end else if (st == S_NORM && all_idle && !cs_s && ca_s[3:0] == OP_BST) begin
					next_st = S_DPD;                                        // RULE15
				end else if (st == S_RST && cs_s) begin
					next_st = S_RST_PD;                                     // RULE16
				end
			end else if (!cke_p && cke_s && cs_s) begin
				if (st == S_ACT_PD || st == S_IDLE_PD) begin
					next_st = S_NORM;                                       // RULE8
				end else if (st == S_RST_PD) begin
					next_st = (itmr == '0) ? S_NORM : S_RST;                // RULE9
				end
			end
		end
		if (exe) begin
			next_pend = 1'b0;
			next_stb  = 1'b1;
			next_cmd  = dcmd;
			next_ba   = bk_ba;                                              // RULE2
			next_row  = {ca_s[9:8], h1[6:2], ca_s[7:0]};
			next_col  = {ca_s[9:1], h1[6:5], 1'b0};                         // RULE6
			next_ap   = ca_s[AP_BIT];
			next_ma   = ma;
			next_op   = ca_s[9:2];
			if (dcmd == CMD_MRW && ma == MA_RESET) begin
				next_st   = S_RST;                                          // RULE17 RULE21
				next_itmr = C_INIT5;
				bk_rst    = 1'b1;
			end else if (dcmd == CMD_MRR && st != S_PWRON) begin
				next_st   = S_BUSY;                                         // RULE17 RULE18 RULE21
				next_ret  = st;
				next_gtmr = C_MRR;
			end else if (st == S_NORM) begin
				bk_go = 1'b1;
				if (dcmd == CMD_MRW) begin
					next_st   = S_BUSY;                                     // RULE17
					next_ret  = S_NORM;
					next_gtmr = C_MRW;
				end else if (dcmd == CMD_REF_AB && all_idle) begin
					next_st   = S_BUSY;                                     // RULE17
					next_ret  = S_NORM;
					next_gtmr = C_RFCAB;
				end else if (dcmd == CMD_RD || dcmd == CMD_WR) begin
					next_last_ba = bk_ba;
				end
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ck_d    <= 1'b0;
			cke_p   <= 1'b0;
			h1      <= '1;
			pend    <= 1'b0;
			st      <= S_PWRON;
			ret     <= S_NORM;
			gtmr    <= '0;
			itmr    <= '0;
			last_ba <= '0;
			cmd_stb_o <= 1'b0;
			cmd_o   <= CMD_NOP;
			ba_o    <= '0;
			row_o   <= '0;
			col_o   <= '0;
			ap_o    <= 1'b0;
			ma_o    <= '0;
			op_o    <= '0;
		end else begin
			ck_d    <= next_ck_d;
			cke_p   <= next_cke_p;
			h1      <= next_h1;
			pend    <= next_pend;
			st      <= next_st;
			ret     <= next_ret;
			gtmr    <= next_gtmr;
			itmr    <= next_itmr;
			last_ba <= next_last_ba;
			cmd_stb_o <= next_stb;
			cmd_o   <= next_cmd;
			ba_o    <= next_ba;
			row_o   <= next_row;
			col_o   <= next_col;
			ap_o    <= next_ap;
			ma_o    <= next_ma;
			op_o    <= next_op;
		end
	end
	assign dev_state_o = st;

	// ****************************************
	// Per-bank state
	// ****************************************
	for (genvar gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
		lpc_bank_t     bs, next_bs;
		logic [TW-1:0] bt, next_bt;
		logic          bap, next_bap;
		logic          hit;

		assign hit = (bk_ba == BA_W'(gi));
		always_comb begin
			next_bs  = bs;
			next_bt  = (bt != '0) ? bt - 1'b1 : bt;
			next_bap = bap;
			if (bt == '0) begin
				case (bs)
					B_OPEN: next_bs = B_ACT;                                // RULE22
					B_PRE, B_REF: next_bs = B_IDLE;                         // RULE22
					B_RD, B_WR: begin
						next_bs = bap ? B_PRE : B_ACT;                      // RULE3
						next_bt = bap ? C_RP : '0;
					end
					default: ;
				endcase
			end
			if (bk_go) begin
				case (dcmd)
					CMD_ACT: if (hit && bs == B_IDLE) begin
						next_bs = B_OPEN;                                   // RULE17
						next_bt = C_RCD;
					end
					CMD_RD, CMD_WR: if (hit && bs inside {B_ACT, B_RD, B_WR}) begin
						next_bs  = (dcmd == CMD_RD) ? B_RD : B_WR;          // RULE18 RULE19 RULE20
						next_bt  = C_BURST;
						next_bap = ca_s[AP_BIT];
					end
					CMD_BST: if (hit && bs inside {B_RD, B_WR} && !bap) begin
						next_bs = B_ACT;                                    // RULE19 RULE20
						next_bt = '0;
					end
					CMD_PRE: if ((hit || h1[AB_BIT]) && bs inside {B_IDLE, B_ACT, B_PRE}) begin
						next_bs = B_PRE;                                    // RULE17 RULE18
						next_bt = C_RP;
					end
					CMD_REF_PB: if (hit && bs == B_IDLE && NUM_BANKS == PB_BANKS) begin
						next_bs = B_REF;                                    // RULE17
						next_bt = C_RFCPB;
					end
					default: ;
				endcase
			end
			if (bk_rst) begin
				next_bs  = B_IDLE;
				next_bt  = '0;
				next_bap = 1'b0;
			end
		end
		always_ff @(posedge core_clk_i) begin
			if (rst_i) begin
				bs  <= B_IDLE;
				bt  <= '0;
				bap <= 1'b0;
			end else begin
				bs  <= next_bs;
				bt  <= next_bt;
				bap <= next_bap;
			end
		end
		assign bank_active_o[gi] = (bs == B_ACT);
		assign bank_idle_o[gi]   = (bs == B_IDLE);
	end
endmodule // lpc_dev

// >>> logic/lpc_pkg.sv
package lpc_pkg;
	// ****************************************
	// Geometry and link
	// ****************************************
	localparam int CLK_MHZ   = 100;
	localparam int NUM_BANKS = 8;
	localparam int PB_BANKS  = 8;
	localparam int CA_W      = 10;
	localparam int BA_W      = 3;
	localparam int TW        = 12;
	localparam int CK_HALF   = 4;
	localparam int BA_LSB    = 7;
	localparam int AB_BIT    = 4;
	localparam int AP_BIT    = 0;

	// ****************************************
	// First-half opcodes on ca[3:0]
	// ****************************************
	localparam logic [3:0] OP_MRW   = 4'h0;
	localparam logic [3:0] OP_MRR   = 4'h8;
	localparam logic [3:0] OP_REFPB = 4'h4;
	localparam logic [3:0] OP_REFAB = 4'hc;
	localparam logic [3:0] OP_PRE   = 4'hb;
	localparam logic [3:0] OP_BST   = 4'h3;
	localparam logic [1:0] OP_ACT   = 2'h2;
	localparam logic [2:0] OP_WR    = 3'h1;
	localparam logic [2:0] OP_RD    = 3'h5;
	localparam logic [7:0] MA_RESET = 8'h3f;

	// ****************************************
	// Timing
	// ****************************************
	localparam int T_RCD_NS   = 18;
	localparam int T_RP_NS    = 18;
	localparam int T_RFCPB_NS = 90;
	localparam int T_RFCAB_NS = 130;
	localparam int T_MRR_NS   = 20;
	localparam int T_MRW_NS   = 50;
	localparam int T_BURST_NS = 160;
	localparam int T_XP_NS    = 8;
	localparam int T_XSR_NS   = 140;
	localparam int T_INIT5_NS = 10000;
	localparam logic [TW-1:0] C_RCD   = TW'((T_RCD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TW-1:0] C_RP    = TW'((T_RP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TW-1:0] C_RFCPB = TW'((T_RFCPB_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TW-1:0] C_RFCAB = TW'((T_RFCAB_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TW-1:0] C_MRR   = TW'((T_MRR_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TW-1:0] C_MRW   = TW'((T_MRW_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TW-1:0] C_BURST = TW'((T_BURST_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TW-1:0] C_XP    = TW'((T_XP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TW-1:0] C_XSR   = TW'((T_XSR_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TW-1:0] C_INIT5 = TW'((T_INIT5_NS * CLK_MHZ + 999) / 1000);
	localparam logic [TW-1:0] C_CKP   = TW'(2 * CK_HALF);

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		CMD_NOP, CMD_MRW, CMD_MRR, CMD_REF_PB, CMD_REF_AB, CMD_ACT, CMD_WR,
		CMD_RD, CMD_PRE, CMD_BST, CMD_SREF, CMD_DPD, CMD_PD, CMD_PD_EXIT
	} lpc_cmd_t;
	typedef enum logic [3:0] {
		S_PWRON, S_RST, S_NORM, S_ACT_PD, S_IDLE_PD, S_RST_PD, S_SREF, S_DPD, S_BUSY
	} lpc_dev_t;
	typedef enum logic [2:0] {
		B_IDLE, B_OPEN, B_ACT, B_RD, B_WR, B_PRE, B_REF
	} lpc_bank_t;
endpackage

// >>> logic/lpc_link_if.sv
`timescale 1ns/10ps
interface lpc_link_if;
	logic                     ck;
	logic                     cke;
	logic                     cs_n;
	logic [lpc_pkg::CA_W-1:0] ca;
	modport ctrl (output ck, output cke, output cs_n, output ca);
	modport dev  (input ck, input cke, input cs_n, input ca);
endinterface

// >>> logic/lpc_ctrl.sv
`timescale 1ns/10ps
module lpc_ctrl
	import lpc_pkg::*;
(
	input  wire logic          core_clk_i,
	input  wire logic          rst_i,
	lpc_link_if.ctrl           link,
	input  wire logic          req_valid_i,
	input  wire lpc_cmd_t      req_cmd_i,
	input  wire logic [BA_W-1:0] req_ba_i,
	input  wire logic [14:0]   req_addr_i,
	input  wire logic          req_ap_i,
	input  wire logic [7:0]    req_op_i,
	output logic               req_ready_o,
	output logic               low_power_o
);
	typedef enum logic [1:0] {Q_RDY, Q_H2, Q_END, Q_WAIT} lpc_cst_t;

	// ****************************************
	// Link clock divider
	// ****************************************
	logic [2:0] cnt;
	logic       ph_r;
	logic       ph_f;

	assign ph_r = (cnt == 3'h6);
	assign ph_f = (cnt == 3'h2);

	// ****************************************
	// Command sequencer
	// ****************************************
	lpc_cst_t        st, next_st;
	logic [2:0]      next_cnt;
	logic            cke, next_cke, cs_n, next_cs_n, lowp, next_lowp, slf, next_slf;
	logic [CA_W-1:0] ca, next_ca, h2, next_h2;
	logic [TW-1:0]   wcnt, next_wcnt;
	logic            legal, take;
	logic [7:0]      ma;
	logic [11:0]     col;

	assign ma  = req_addr_i[7:0];
	assign col = req_addr_i[11:0];

	always_comb begin
		legal = !lowp && (req_cmd_i != CMD_NOP) && (req_cmd_i != CMD_PD_EXIT);
		if (req_cmd_i == CMD_PD_EXIT) begin
			legal = lowp;
		end else if (req_cmd_i == CMD_REF_PB) begin
			legal = !lowp && (NUM_BANKS == PB_BANKS);                       // RULE5
		end
	end
	assign req_ready_o = (st == Q_RDY) && ph_r && legal;
	assign take        = req_valid_i && req_ready_o;

	always_comb begin
		next_cnt  = cnt + 1'b1;
		next_st   = st;
		next_cke  = cke;
		next_cs_n = cs_n;
		next_ca   = ca;
		next_h2   = h2;
		next_lowp = lowp;
		next_slf  = slf;
		next_wcnt = (wcnt != '0) ? wcnt - 1'b1 : wcnt;
		case (st)
			Q_RDY: if (take) begin
				next_cs_n = 1'b0;                                           // RULE1
				next_cke  = 1'b1;
				next_ca   = '1;
				next_h2   = '1;
				next_st   = Q_H2;
				case (req_cmd_i)
					CMD_MRW: begin
						next_ca = {ma[5:0], OP_MRW};
						next_h2 = {req_op_i, ma[7:6]};
					end
					CMD_MRR: begin
						next_ca = {ma[5:0], OP_MRR};
						next_h2 = {8'hff, ma[7:6]};
					end
					CMD_REF_PB: next_ca = {6'h3f, OP_REFPB};
					CMD_REF_AB: next_ca = {6'h3f, OP_REFAB};
					CMD_ACT: begin
						next_ca = {req_ba_i, req_addr_i[12:8], OP_ACT};
						next_h2 = {req_addr_i[14:13], req_addr_i[7:0]};
					end
					CMD_WR, CMD_RD: begin
						next_ca = {req_ba_i, col[2:1], 2'h3, (req_cmd_i == CMD_RD) ? OP_RD : OP_WR};
						next_h2 = {col[11:3], req_ap_i};
					end
					CMD_PRE: next_ca = {req_ba_i, 2'h3, req_ap_i, OP_PRE};
					CMD_BST: next_ca = {6'h3f, OP_BST};
					CMD_SREF, CMD_DPD: begin
						next_cke  = 1'b0;
						next_ca   = {6'h3f, (req_cmd_i == CMD_SREF) ? OP_REFPB : OP_BST};
						next_lowp = 1'b1;
						next_slf  = (req_cmd_i == CMD_SREF);
					end
					CMD_PD: begin
						next_cke  = 1'b0;
						next_cs_n = 1'b1;
						next_lowp = 1'b1;
						next_slf  = 1'b0;
					end
					CMD_PD_EXIT: begin
						next_cke  = 1'b1;                                   // RULE8 RULE10
						next_cs_n = 1'b1;
						next_lowp = 1'b0;
						next_wcnt = (slf ? C_XSR : C_XP) + C_CKP;           // RULE11 RULE12
					end
					default: ;
				endcase
			end
			Q_H2: if (ph_f) begin
				next_ca = h2;
				next_st = Q_END;
			end
			Q_END: if (ph_r) begin
				next_cs_n = 1'b1;
				next_ca   = '1;
				next_st   = Q_WAIT;
			end
			Q_WAIT: if (wcnt == '0) next_st = Q_RDY;                        // RULE11 RULE12
			default: next_st = Q_RDY;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cnt  <= '0;
			st   <= Q_RDY;
			cke  <= 1'b1;
			cs_n <= 1'b1;
			ca   <= '1;
			h2   <= '1;
			lowp <= 1'b0;
			slf  <= 1'b0;
			wcnt <= '0;
		end else begin
			cnt  <= next_cnt;
			st   <= next_st;
			cke  <= next_cke;
			cs_n <= next_cs_n;
			ca   <= next_ca;
			h2   <= next_h2;
			lowp <= next_lowp;
			slf  <= next_slf;
			wcnt <= next_wcnt;
		end
	end

	// Clock keeps toggling in every state, power-down and exit waits included
	assign link.ck     = ~cnt[2];
	assign link.cke    = cke;
	assign link.cs_n   = cs_n;
	assign link.ca     = ca;
	assign low_power_o = lowp;
endmodule // lpc_ctrl

// >>> dv/lpc_link_properties.sv
`timescale 1ns/10ps
module lpc_link_properties
	import lpc_pkg::*;
(
	input wire logic                 core_clk_i,
	input wire logic                 rst_i,
	input wire logic                 ck,
	input wire logic                 cke,
	input wire logic                 cs_n,
	input wire logic [CA_W-1:0]      ca,
	input wire lpc_dev_t             dev_state_o,
	input wire logic [NUM_BANKS-1:0] bank_active_o,
	input wire logic [NUM_BANKS-1:0] bank_idle_o,
	input wire logic                 cmd_stb_o,
	input wire logic [11:0]          col_o
);
	default clocking dcb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	// ****************************************
	// Link pins
	// ****************************************
	ck_high_a: assert property ($rose(ck) |-> ck [*4] ##1 !ck)
		else $error("link clock high phase wrong");
	ck_low_a: assert property ($fell(ck) |-> !ck [*4] ##1 ck)
		else $error("link clock low phase wrong");
	rise_hold_a: assert property ($rose(ck) |-> $stable(cs_n) && $stable(cke) && $stable(ca))
		else $error("link pins moved at clock rise");
	fall_hold_a: assert property ($fell(ck) |-> $stable(ca) && $stable(cs_n))
		else $error("link pins moved at clock fall");

	// ****************************************
	// Device state
	// ****************************************
	col_zero_a: assert property (cmd_stb_o |-> col_o[0] == 1'b0)
		else $error("column bit zero not zero");
	bank_excl_a: assert property ((bank_active_o & bank_idle_o) == '0)
		else $error("bank both idle and active");
	pd_hold_a: assert property ((!cke) [*8] ##0 (dev_state_o inside {S_ACT_PD, S_IDLE_PD, S_RST_PD, S_SREF, S_DPD})
		|=> $stable(dev_state_o))
		else $error("low power state left with clock enable low");
	idle_pd_a: assert property ($rose(dev_state_o == S_IDLE_PD) |-> &$past(bank_idle_o))
		else $error("idle power down with a bank busy");
	act_pd_a: assert property ($rose(dev_state_o == S_ACT_PD) |-> !(&$past(bank_idle_o)))
		else $error("active power down with all banks idle");
	pd_exit_a: assert property (($past(dev_state_o) inside {S_ACT_PD, S_IDLE_PD, S_SREF})
		&& (dev_state_o != $past(dev_state_o)) |-> dev_state_o == S_NORM)
		else $error("power down exit to wrong state");
	dpd_exit_a: assert property (($past(dev_state_o) == S_DPD) && (dev_state_o != S_DPD)
		|-> dev_state_o == S_PWRON)
		else $error("deep power down exit to wrong state");
	async_exit_a: assert property ((cke && cs_n) [*6] |-> !(dev_state_o inside {S_SREF, S_DPD}))
		else $error("self refresh or deep power down not left");

	cover property (dev_state_o == S_SREF);
	cover property (dev_state_o == S_DPD);
	cover property (dev_state_o == S_RST_PD);
	cover property (dev_state_o == S_ACT_PD);
endmodule // lpc_link_properties

// >>> dv/tb_lpddr2_command_power_state.sv
`timescale 1ns/10ps
module tb_lpddr2_command_power_state
	import lpc_pkg::*;
;
	logic                 core_clk_i;
	logic                 rst_i;
	logic                 req_valid_i;
	lpc_cmd_t             req_cmd_i;
	logic [BA_W-1:0]      req_ba_i;
	logic [14:0]          req_addr_i;
	logic                 req_ap_i;
	logic [7:0]           req_op_i;
	logic                 req_ready_o;
	logic                 low_power_o;
	lpc_dev_t             dev_state_o;
	logic [NUM_BANKS-1:0] bank_active_o;
	logic [NUM_BANKS-1:0] bank_idle_o;
	logic                 cmd_stb_o;
	lpc_cmd_t             cmd_o;
	logic [BA_W-1:0]      ba_o;
	logic [14:0]          row_o;
	logic [11:0]          col_o;
	logic                 ap_o;
	logic [7:0]           ma_o;
	logic [7:0]           op_o;
	int                   fail_count;
	int                   cmp_count;

	lpc_link_if lpc_link_if_i ();
	lpc_ctrl lpc_ctrl_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(lpc_link_if_i.ctrl),
		.req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i), .req_ba_i(req_ba_i), .req_addr_i(req_addr_i),
		.req_ap_i(req_ap_i), .req_op_i(req_op_i), .req_ready_o(req_ready_o), .low_power_o(low_power_o));
	lpc_dev lpc_dev_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(lpc_link_if_i.dev),
		.dev_state_o(dev_state_o), .bank_active_o(bank_active_o), .bank_idle_o(bank_idle_o),
		.cmd_stb_o(cmd_stb_o), .cmd_o(cmd_o), .ba_o(ba_o), .row_o(row_o), .col_o(col_o), .ap_o(ap_o),
		.ma_o(ma_o), .op_o(op_o));
	lpc_link_properties lpc_link_properties_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.ck(lpc_link_if_i.ck), .cke(lpc_link_if_i.cke), .cs_n(lpc_link_if_i.cs_n), .ca(lpc_link_if_i.ca),
		.dev_state_o(dev_state_o), .bank_active_o(bank_active_o), .bank_idle_o(bank_idle_o),
		.cmd_stb_o(cmd_stb_o), .col_o(col_o));

	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	// ****************************************
	// Checking and waiting helpers
	// ****************************************
	task automatic final_report();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			$display("FAIL %0t %s", $time, msg);
			fail_count++;
		end
	endtask

	task automatic hang(input string msg);
		$display("FAIL %0t timeout %s", $time, msg);
		fail_count++;
		final_report();
	endtask

	// One request on the user port, held until the edge that takes it
	task automatic send(input lpc_cmd_t c, input logic [2:0] b, input logic [14:0] a, input logic p);
		int n;
		n = 0;
		@(posedge core_clk_i);
		req_cmd_i <= c;
		req_ba_i <= b;
		req_addr_i <= a;
		req_ap_i <= p;
		req_op_i <= 8'h5c;
		req_valid_i <= 1'b1;
		@(negedge core_clk_i);
		while (req_ready_o !== 1'b1) begin
			n++;
			if (n > 400) hang("request not taken");
			@(negedge core_clk_i);
		end
		@(posedge core_clk_i);
		req_valid_i <= 1'b0;
	endtask

	task automatic got(input lpc_cmd_t c, input string msg);
		int n;
		n = 0;
		@(negedge core_clk_i);
		while (cmd_stb_o !== 1'b1) begin
			n++;
			if (n > 80) hang(msg);
			@(negedge core_clk_i);
		end
		chk(cmd_o === c, msg);
	endtask

	task automatic leave(input lpc_dev_t from, input lpc_dev_t to, input string msg);
		int n;
		n = 0;
		@(negedge core_clk_i);
		while (dev_state_o === from) begin
			n++;
			if (n > 200) hang(msg);
			@(negedge core_clk_i);
		end
		chk(dev_state_o === to, msg);
	endtask

	// Waits for bank b to read idle (want_idle) or active
	task automatic wait_bank(input logic want_idle, input int b, input int lim, input string msg);
		int n;
		n = 0;
		@(negedge core_clk_i);
		while ((want_idle ? bank_idle_o[b] : bank_active_o[b]) !== 1'b1) begin
			n++;
			if (n > lim) hang(msg);
			@(negedge core_clk_i);
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_init();
		chk(dev_state_o === S_PWRON, "state after reset");
		send(CMD_MRW, 3'h0, {7'h00, MA_RESET}, 1'b0);
		got(CMD_MRW, "reset command");
		chk(ma_o === MA_RESET, "reset address");
		leave(S_PWRON, S_RST, "reset starts init");
		send(CMD_MRR, 3'h0, 15'h0005, 1'b0);
		got(CMD_MRR, "read while resetting");
		chk(ma_o === 8'h05, "mode read address");
		leave(S_RST, S_BUSY, "resetting mode read");
		leave(S_BUSY, S_RST, "back to resetting");
		send(CMD_PD, 3'h0, 15'h0000, 1'b0);
		leave(S_RST, S_RST_PD, "resetting power down");
		send(CMD_PD_EXIT, 3'h0, 15'h0000, 1'b0);
		leave(S_RST_PD, S_RST, "early exit stays resetting");
		send(CMD_PD, 3'h0, 15'h0000, 1'b0);
		leave(S_RST, S_RST_PD, "resetting power down again");
		repeat (int'(C_INIT5) + 50) @(posedge core_clk_i);
		chk(dev_state_o === S_RST_PD, "held in power down");
		send(CMD_PD_EXIT, 3'h0, 15'h0000, 1'b0);
		leave(S_RST_PD, S_NORM, "late exit goes idle");
	endtask

	task automatic t_idle_cmds();
		lpc_cmd_t cl [5] = '{CMD_MRW, CMD_MRR, CMD_REF_AB, CMD_REF_PB, CMD_PRE};
		int n;
		for (int i = 0; i < 5; i++) begin
			send(cl[i], 3'h3, 15'h002a, i == 4);
			got(cl[i], "idle command decode");
			if (i < 2) chk(ma_o === 8'h2a, "mode address");
			if (i == 0) chk(op_o === 8'h5c, "mode write data");
			n = 0;
			while (!(dev_state_o === S_NORM && bank_idle_o === '1)) begin
				n++;
				if (n > 100) hang("idle command never ends");
				@(negedge core_clk_i);
			end
		end
	endtask

	task automatic t_bank();
		send(CMD_ACT, 3'h5, 15'h5a3c, 1'b0);
		got(CMD_ACT, "activate");
		chk(ba_o === 3'h5, "bank select");
		chk(row_o === 15'h5a3c, "row address");
		chk(bank_active_o[5] === 1'b0, "active before row delay");
		wait_bank(1'b0, 5, 40, "row never active");
		chk(bank_idle_o[4] === 1'b1 && bank_active_o[4] === 1'b0, "other bank untouched");
		send(CMD_RD, 3'h5, 15'h00a7, 1'b0);
		got(CMD_RD, "read");
		chk(col_o === 12'h0a6, "read column");
		chk(bank_active_o[5] === 1'b0, "read burst running");
		send(CMD_WR, 3'h5, 15'h00f1, 1'b0);
		got(CMD_WR, "write after read");
		chk(col_o === 12'h0f0, "write column");
		send(CMD_BST, 3'h5, 15'h0000, 1'b0);
		got(CMD_BST, "terminate");
		wait_bank(1'b0, 5, 20, "terminate not active");
		send(CMD_RD, 3'h5, 15'h0010, 1'b1);
		got(CMD_RD, "read with precharge");
		chk(ap_o === 1'b1, "auto precharge flag");
		wait_bank(1'b1, 5, int'(C_BURST) + int'(C_RP) + 40, "no auto precharge");
	endtask

	task automatic t_power();
		send(CMD_ACT, 3'h1, 15'h0011, 1'b0);
		wait_bank(1'b0, 1, 60, "row never active");
		send(CMD_PD, 3'h0, 15'h0000, 1'b0);
		leave(S_NORM, S_ACT_PD, "active power down");
		chk(low_power_o === 1'b1, "controller low power flag");
		repeat (30) @(posedge core_clk_i);
		chk(dev_state_o === S_ACT_PD, "active power down held");
		send(CMD_PD_EXIT, 3'h0, 15'h0000, 1'b0);
		leave(S_ACT_PD, S_NORM, "active power down exit");
		send(CMD_PRE, 3'h1, 15'h0000, 1'b0);
		wait_bank(1'b1, 1, 60, "precharge not idle");
		send(CMD_PD, 3'h0, 15'h0000, 1'b0);
		leave(S_NORM, S_IDLE_PD, "idle power down");
		send(CMD_PD_EXIT, 3'h0, 15'h0000, 1'b0);
		leave(S_IDLE_PD, S_NORM, "idle power down exit");
		send(CMD_SREF, 3'h0, 15'h0000, 1'b0);
		leave(S_NORM, S_SREF, "self refresh entry");
		send(CMD_PD_EXIT, 3'h0, 15'h0000, 1'b0);
		leave(S_SREF, S_NORM, "self refresh exit");
		send(CMD_DPD, 3'h0, 15'h0000, 1'b0);
		leave(S_NORM, S_DPD, "deep power down entry");
		send(CMD_PD_EXIT, 3'h0, 15'h0000, 1'b0);
		leave(S_DPD, S_PWRON, "deep power down exit");
	endtask

	initial begin
		fail_count = 0;
		cmp_count = 0;
		rst_i = 1'b1;
		req_valid_i = 1'b0;
		req_cmd_i = CMD_NOP;
		req_ba_i = 3'h0;
		req_addr_i = 15'h0000;
		req_ap_i = 1'b0;
		req_op_i = 8'h00;
		repeat (3) @(posedge core_clk_i);
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		t_init();
		t_idle_cmds();
		t_bank();
		t_power();
		final_report();
	end
endmodule // tb_lpddr2_command_power_state
